/* File: include/adc_seq_pkg.sv */
// Constants, states and field layout for the serial converter sequencer
package adc_seq_pkg;

   // Clock and timing
   localparam int SYS_PERIOD_PS = 5000;
   localparam int BIT_STEP_NS   = 1500;
   localparam int BIT_STEP_CYC  = (BIT_STEP_NS * 1000 + SYS_PERIOD_PS - 1) / SYS_PERIOD_PS;
   localparam int STEP_W        = 9;
   localparam logic [STEP_W-1:0] STEP_LAST = STEP_W'(BIT_STEP_CYC - 1);

   // Widths
   localparam int RES_W  = 10;
   localparam int ADDR_W = 4;
   localparam int CH_N   = 14;
   localparam int CNT_W  = 5;

   // Serial clock falling edge numbers
   localparam logic [CNT_W-1:0] FALL_ADDR  = 5'h04;
   localparam logic [CNT_W-1:0] FALL_HOLD  = 5'h0a;
   localparam logic [CNT_W-1:0] FALL_LONG  = 5'h10;
   localparam logic [CNT_W-1:0] CNT_RST    = 5'h00;
   localparam logic [CNT_W-1:0] CNT_ONE    = 5'h01;

   // Channel codes
   localparam logic [ADDR_W-1:0] CODE_EXT_LAST = 4'ha;
   localparam logic [ADDR_W-1:0] CODE_MID      = 4'hb;
   localparam logic [ADDR_W-1:0] CODE_LOW      = 4'hc;
   localparam logic [ADDR_W-1:0] CODE_HIGH     = 4'hd;

   // Reset values and weights
   localparam logic [RES_W-1:0]  RESULT_RST = 10'h000;
   localparam logic [RES_W-1:0]  MSB_WEIGHT = 10'h200;
   localparam logic [CH_N-1:0]   CHAN_OFF   = 14'h0000;

   // Sequencer states
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_XFER = 4'b0010,
      ST_CONV = 4'b0100,
      ST_HOLD = 4'b1000
   } seq_state_t;

endpackage : adc_seq_pkg

/* File: design/serial_adc_sequencer.sv */
// Serial port, sample timing and successive approximation sequencer
`timescale 1ns/100ps
module serial_adc_sequencer (
   // System clock and reset
   input  wire logic                             clk_sys,
   input  wire logic                             rst,
   // Host serial port
   input  wire logic                             io_clk,
   input  wire logic                             cs_n,
   input  wire logic                             addr_in,
   output logic                                  data_out,
   output logic                                  data_out_oe,
   output logic                                  eoc,
   // Analog front end control
   output logic [adc_seq_pkg::CH_N-1:0]          channel_sel,
   output logic                                  sample_en,
   output logic [adc_seq_pkg::RES_W-1:0]         dac_code,
   input  wire logic                             cmp_above,
   // Last completed result
   output logic [adc_seq_pkg::RES_W-1:0]         result
);

   // One-hot multiplexer decode, unused codes open all inputs
   function automatic logic [adc_seq_pkg::CH_N-1:0] chan_onehot(
      input logic [adc_seq_pkg::ADDR_W-1:0] code
   );
      logic [adc_seq_pkg::CH_N-1:0] sel;
      sel = adc_seq_pkg::CHAN_OFF;
      if (code <= adc_seq_pkg::CODE_HIGH) begin
         sel[code] = 1'b1;
      end
      return sel;
   endfunction : chan_onehot

   // Link domain address shifter
   logic [adc_seq_pkg::ADDR_W-1:0] addr_shift_reg;

   // Synchronisers
   logic cs_meta_reg;
   logic cs_sync_reg;
   logic cs_prev_reg;
   logic sclk_meta_reg;
   logic sclk_sync_reg;
   logic sclk_prev_reg;
   logic cmp_meta_reg;
   logic cmp_sync_reg;

   // Sequencer state
   adc_seq_pkg::seq_state_t          state_reg;
   adc_seq_pkg::seq_state_t          state_next;
   logic [adc_seq_pkg::CNT_W-1:0]    fall_cnt_reg;
   logic                             late_rise_reg;
   logic [adc_seq_pkg::RES_W-1:0]    shift_reg;
   logic                             oe_reg;
   logic                             eoc_reg;
   logic                             sample_reg;
   logic [adc_seq_pkg::ADDR_W-1:0]   mux_code_reg;
   logic                             mux_pend_reg;
   logic [adc_seq_pkg::CH_N-1:0]     chan_reg;
   logic [adc_seq_pkg::STEP_W-1:0]   step_cnt_reg;
   logic [adc_seq_pkg::RES_W-1:0]    trial_reg;
   logic [adc_seq_pkg::RES_W-1:0]    weight_reg;
   logic [adc_seq_pkg::RES_W-1:0]    result_reg;

   // Decoded events
   logic                             cs_low;
   logic                             cs_fall;
   logic                             fall_ev;
   logic                             rise_ev;
   logic [adc_seq_pkg::CNT_W-1:0]    fall_num;
   logic                             at_addr;
   logic                             at_hold;
   logic                             at_long;
   logic                             step_done;
   logic                             conv_done;
   logic [adc_seq_pkg::RES_W-1:0]    bit_value;
   logic                             restart;

   // Address bits shift in on serial clock rising edges
   always_ff @(posedge io_clk) begin
      addr_shift_reg <= {addr_shift_reg[adc_seq_pkg::ADDR_W-2:0], addr_in};
   end

   // Select synchroniser plus edge history, idles high
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cs_meta_reg <= 1'b1;
         cs_sync_reg <= 1'b1;
         cs_prev_reg <= 1'b1;
      end else begin
         cs_meta_reg <= cs_n;
         cs_sync_reg <= cs_meta_reg;
         cs_prev_reg <= cs_sync_reg;
      end
   end

   // Serial clock synchroniser plus edge history, idles low
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         sclk_meta_reg <= 1'b0;
         sclk_sync_reg <= 1'b0;
         sclk_prev_reg <= 1'b0;
      end else begin
         sclk_meta_reg <= io_clk;
         sclk_sync_reg <= sclk_meta_reg;
         sclk_prev_reg <= sclk_sync_reg;
      end
   end

   // Comparator synchroniser
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cmp_meta_reg <= 1'b0;
         cmp_sync_reg <= 1'b0;
      end else begin
         cmp_meta_reg <= cmp_above;
         cmp_sync_reg <= cmp_meta_reg;
      end
   end

   // Serial clock is honoured only while select is low
   assign cs_low   = ~cs_sync_reg;
   assign cs_fall  = cs_prev_reg & ~cs_sync_reg;
   assign fall_ev  = cs_low & sclk_prev_reg & ~sclk_sync_reg;
   assign rise_ev  = cs_low & ~sclk_prev_reg & sclk_sync_reg;
   assign fall_num = fall_cnt_reg + adc_seq_pkg::CNT_ONE;
   assign at_addr  = fall_ev & (state_reg == adc_seq_pkg::ST_XFER)
                     & (fall_num == adc_seq_pkg::FALL_ADDR);
   assign at_hold  = fall_ev & (state_reg == adc_seq_pkg::ST_XFER)
                     & (fall_num == adc_seq_pkg::FALL_HOLD);
   assign at_long  = fall_ev & (fall_num == adc_seq_pkg::FALL_LONG);

   // Approximation step decision
   assign step_done = (state_reg == adc_seq_pkg::ST_CONV)
                      & (step_cnt_reg == adc_seq_pkg::STEP_LAST);
   assign conv_done = step_done & weight_reg[0];
   assign bit_value = cmp_sync_reg ? (trial_reg & ~weight_reg) : trial_reg;

   // New sequence with select held low
   always_comb begin
      restart = 1'b0;
      if (!cs_fall && cs_low) begin
         if (conv_done) begin
            restart = ((fall_cnt_reg == adc_seq_pkg::FALL_HOLD) & ~late_rise_reg)
                      | (fall_cnt_reg == adc_seq_pkg::FALL_LONG) | at_long;
         end else if (state_reg == adc_seq_pkg::ST_HOLD) begin
            restart = at_long;
         end
      end
   end

   // Sequencer state machine
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         adc_seq_pkg::ST_IDLE: begin
            if (cs_fall) begin
               state_next = adc_seq_pkg::ST_XFER;
            end
         end
         adc_seq_pkg::ST_XFER: begin
            if (cs_fall) begin
               state_next = adc_seq_pkg::ST_XFER;
            end else if (at_hold) begin
               state_next = adc_seq_pkg::ST_CONV;
            end else if (!cs_low) begin
               state_next = adc_seq_pkg::ST_IDLE;
            end
         end
         adc_seq_pkg::ST_CONV: begin
            if (cs_fall) begin
               state_next = adc_seq_pkg::ST_XFER;
            end else if (restart) begin
               state_next = adc_seq_pkg::ST_XFER;
            end else if (conv_done) begin
               state_next = cs_low ? adc_seq_pkg::ST_HOLD : adc_seq_pkg::ST_IDLE;
            end
         end
         adc_seq_pkg::ST_HOLD: begin
            if (cs_fall || restart) begin
               state_next = adc_seq_pkg::ST_XFER;
            end else if (!cs_low) begin
               state_next = adc_seq_pkg::ST_IDLE;
            end
         end
         default: begin
            state_next = adc_seq_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state_reg <= adc_seq_pkg::ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // Falling edge counter, saturates at sixteen
   always_ff @(posedge clk_sys) begin
      if (rst || cs_fall || restart) begin
         fall_cnt_reg <= adc_seq_pkg::CNT_RST;
      end else if (fall_ev && fall_cnt_reg != adc_seq_pkg::FALL_LONG) begin
         fall_cnt_reg <= fall_num;
      end
   end

   // Rising edge seen after the tenth falling edge
   always_ff @(posedge clk_sys) begin
      if (rst || cs_fall || restart || at_hold) begin
         late_rise_reg <= 1'b0;
      end else if (rise_ev && fall_cnt_reg >= adc_seq_pkg::FALL_HOLD) begin
         late_rise_reg <= 1'b1;
      end
   end

   // Output driver enable follows select
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         oe_reg <= 1'b0;
      end else begin
         oe_reg <= cs_low;
      end
   end

   // Result shifter feeding the serial output
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         shift_reg <= adc_seq_pkg::RESULT_RST;
      end else if (cs_fall) begin
         shift_reg <= result_reg;
      end else if (restart) begin
         shift_reg <= conv_done ? bit_value : result_reg;
      end else if (at_hold) begin
         shift_reg <= adc_seq_pkg::RESULT_RST;
      end else if (fall_ev && state_reg == adc_seq_pkg::ST_XFER) begin
         shift_reg <= {shift_reg[adc_seq_pkg::RES_W-2:0], 1'b0};
      end
   end

   // End of conversion flag
   always_ff @(posedge clk_sys) begin
      if (rst || cs_fall) begin
         eoc_reg <= 1'b1;
      end else if (at_hold) begin
         eoc_reg <= 1'b0;
      end else if (conv_done) begin
         eoc_reg <= 1'b1;
      end
   end

   // Sampling window
   always_ff @(posedge clk_sys) begin
      if (rst || cs_fall || restart) begin
         sample_reg <= 1'b0;
      end else if (at_addr) begin
         sample_reg <= 1'b1;
      end else if (at_hold) begin
         sample_reg <= 1'b0;
      end
   end

   // Channel code captured once the address is complete
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         mux_code_reg <= adc_seq_pkg::CODE_LOW;
      end else if (at_addr && !cs_fall && !restart) begin
         mux_code_reg <= addr_shift_reg;
      end
   end

   // Close request pending for one cycle after the open
   always_ff @(posedge clk_sys) begin
      if (rst || cs_fall || restart || at_hold) begin
         mux_pend_reg <= 1'b0;
      end else if (at_addr) begin
         mux_pend_reg <= 1'b1;
      end else if (mux_pend_reg) begin
         mux_pend_reg <= 1'b0;
      end
   end

   // Channel select, opened one cycle before the new input closes
   always_ff @(posedge clk_sys) begin
      if (rst || cs_fall || restart || at_hold || at_addr) begin
         chan_reg <= adc_seq_pkg::CHAN_OFF;
      end else if (mux_pend_reg) begin
         chan_reg <= chan_onehot(mux_code_reg);
      end
   end

   // Bit step timer, one approximation step per period
   always_ff @(posedge clk_sys) begin
      if (rst || cs_fall || at_hold || step_done) begin
         step_cnt_reg <= '0;
      end else if (state_reg == adc_seq_pkg::ST_CONV) begin
         step_cnt_reg <= step_cnt_reg + 9'h001;
      end
   end

   // Trial weight walks from the top bit down
   always_ff @(posedge clk_sys) begin
      if (rst || cs_fall) begin
         weight_reg <= adc_seq_pkg::RESULT_RST;
      end else if (at_hold) begin
         weight_reg <= adc_seq_pkg::MSB_WEIGHT;
      end else if (step_done) begin
         weight_reg <= weight_reg >> 1;
      end
   end

   // Successive approximation trial code
   always_ff @(posedge clk_sys) begin
      if (rst || cs_fall) begin
         trial_reg <= adc_seq_pkg::RESULT_RST;
      end else if (at_hold) begin
         trial_reg <= adc_seq_pkg::MSB_WEIGHT;
      end else if (step_done) begin
         trial_reg <= bit_value | (weight_reg >> 1);
      end
   end

   // Completed result, untouched by an abort
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         result_reg <= adc_seq_pkg::RESULT_RST;
      end else if (conv_done && !cs_fall) begin
         result_reg <= bit_value;
      end
   end

   // Outputs
   assign data_out    = shift_reg[adc_seq_pkg::RES_W-1];
   assign data_out_oe = oe_reg;
   assign eoc         = eoc_reg;
   assign channel_sel = chan_reg;
   assign sample_en   = sample_reg;
   assign dac_code    = trial_reg;
   assign result      = result_reg;

endmodule : serial_adc_sequencer

/* File: verification/adc_seq_properties.sv */
// Port checks for the serial converter sequencer
`timescale 1ns/100ps
module adc_seq_properties (
   // System clock and reset
   input wire logic                             clk_sys,
   input wire logic                             rst,
   // Serial port
   input wire logic                             cs_n,
   input wire logic                             data_out,
   input wire logic                             data_out_oe,
   input wire logic                             eoc,
   // Front end and result
   input wire logic [adc_seq_pkg::CH_N-1:0]     channel_sel,
   input wire logic                             sample_en,
   input wire logic [adc_seq_pkg::RES_W-1:0]    dac_code,
   input wire logic [adc_seq_pkg::RES_W-1:0]    result
);
   localparam int CONV_MIN = 2990;
   localparam int CONV_MAX = 3010;
   logic [11:0] low_cnt_reg;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   // Cycles spent converting
   always_ff @(posedge clk_sys) begin
      if (rst || eoc) low_cnt_reg <= 12'h000;
      else low_cnt_reg <= low_cnt_reg + 12'h001;
   end
   sequence s_conv_start;
      $fell(eoc);
   endsequence
   sequence s_conv_end;
      $changed(result);
   endsequence
   a_oe_on_select: assert property ($fell(cs_n) |-> ##[1:4] data_out_oe)
      else $error("Output not enabled after select fall");
   a_oe_off_idle: assert property (cs_n [*5] |-> !data_out_oe)
      else $error("Output still enabled with select high");
   a_start_effects: assert property (s_conv_start |-> !sample_en && !data_out)
      else $error("Sampling or output not stopped at conversion start");
   a_trial_msb: assert property (s_conv_start |-> dac_code == adc_seq_pkg::MSB_WEIGHT)
      else $error("First trial code is not the top weight");
   a_result_done: assert property (s_conv_end |-> $rose(eoc))
      else $error("Result changed without done flag rising");
   a_conv_length: assert property (s_conv_end |-> low_cnt_reg >= CONV_MIN && low_cnt_reg <= CONV_MAX)
      else $error("Conversion length out of range");
   a_mux_single: assert property ($onehot0(channel_sel))
      else $error("Two multiplexer inputs closed");
   a_mux_break: assert property ($changed(channel_sel) |-> $past(channel_sel) == '0 || channel_sel == '0)
      else $error("Multiplexer switched without opening");
   a_sample_idle: assert property (sample_en |-> eoc)
      else $error("Sampling during conversion");
   a_dout_low_conv: assert property (!eoc && data_out_oe && $past(data_out_oe) |-> !data_out)
      else $error("Output not low during conversion");
endmodule : adc_seq_properties
bind serial_adc_sequencer adc_seq_properties chk_u (.clk_sys(clk_sys), .rst(rst), .cs_n(cs_n),
   .data_out(data_out), .data_out_oe(data_out_oe), .eoc(eoc), .channel_sel(channel_sel),
   .sample_en(sample_en), .dac_code(dac_code), .result(result));

/* File: verification/host_model.sv */
// Host serial port model: select, link clock, address and result capture
`timescale 1ns/100ps
module host_model (
   // Link outputs
   output logic      io_clk,
   output logic      cs_n,
   output logic      addr_in,
   // Result line as the host sees it
   input  wire logic data_pin
);
   initial begin
      io_clk = 1'b0;
      cs_n = 1'b1;
      addr_in = 1'b0;
   end
   // One transfer of n clocks, stall of gap ns before clock 12
   task automatic xfer(input logic [3:0] code, input int n, input bit keep, input int gap,
                       output logic [15:0] rx);
      #1.3;
      if (cs_n) begin
         cs_n = 1'b0;
         #1500;
      end
      rx = 16'h0000;
      for (int i = 0; i < n; i++) begin
         if (i == 11) #(gap);
         addr_in = (i < 4) ? code[3 - i] : ~addr_in;
         #62.5 io_clk = 1'b1;
         rx = {rx[14:0], data_pin};
         #62.5 io_clk = 1'b0;
      end
      #200;
      if (!keep) cs_n = 1'b1;
      #100;
   endtask : xfer
endmodule : host_model

/* File: verification/serial_adc_interface_sequencer_tb.sv */
// Self-checking bench for the serial converter sequencer
`timescale 1ns/100ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_fail++; \
   $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module serial_adc_interface_sequencer_tb;
   logic                            clk_sys, rst, cmp_above;
   wire                             io_clk, cs_n, addr_in, data_out, data_out_oe, eoc, sample_en;
   wire [adc_seq_pkg::CH_N-1:0]     channel_sel;
   wire [adc_seq_pkg::RES_W-1:0]    dac_code, result;
   logic [adc_seq_pkg::RES_W-1:0]   held, prev;
   logic [15:0]                     rx;
   int                              n_fail, n_checks;
   // Line goes to inverse when not driven
   wire data_pin = data_out_oe ? data_out : ~data_out;
   serial_adc_sequencer dut_u (.clk_sys(clk_sys), .rst(rst), .io_clk(io_clk), .cs_n(cs_n),
      .addr_in(addr_in), .data_out(data_out), .data_out_oe(data_out_oe), .eoc(eoc),
      .channel_sel(channel_sel), .sample_en(sample_en), .dac_code(dac_code),
      .cmp_above(cmp_above), .result(result));
   host_model host_u (.io_clk(io_clk), .cs_n(cs_n), .addr_in(addr_in), .data_pin(data_pin));
   function automatic logic [9:0] lvl(input int c);
      if (c == 11) return 10'h200;
      if (c == 12) return 10'h000;
      if (c == 13) return 10'h3ff;
      return 10'(10'h05b + c * 10'h041);
   endfunction : lvl
   function automatic logic [15:0] expv(input logic [9:0] p, input int n);
      return 16'({p, 6'h00} >> (16 - n));
   endfunction : expv
   // Held input level and comparator
   always @(negedge clk_sys) begin
      for (int k = 0; k < adc_seq_pkg::CH_N; k++)
         if (sample_en && channel_sel[k]) held <= lvl(k);
      cmp_above <= (dac_code > held);
   end
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   initial begin
      #450000;
      n_fail++;
      print_verdict();
   end
   task automatic wait_eoc;
      int k;
      k = 0;
      repeat (60) @(negedge clk_sys);
      while (eoc !== 1'b1 && k < 4000) begin
         @(negedge clk_sys);
         k++;
      end
      `CHK(eoc, 1'b1)
   endtask : wait_eoc
   task automatic t_sweep;
      for (int c = 0; c < 14; c++) begin
         host_u.xfer(4'(c), 10 + c % 7, 1'b0, (c == 6) ? 16000 : 0, rx);
         `CHK(rx, expv(prev, 10 + c % 7))
         `CHK(data_out_oe, 1'b0)
         `CHK(eoc, 1'(c == 6))
         wait_eoc();
         `CHK(result, lvl(c))
         prev = lvl(c);
      end
   endtask : t_sweep
   task automatic t_abort;
      host_u.xfer(4'h5, 10, 1'b0, 0, rx);
      repeat (500) @(negedge clk_sys);
      host_u.xfer(4'h1, 10, 1'b0, 0, rx);
      `CHK(rx, expv(prev, 10))
      repeat (2200) @(negedge clk_sys);
      `CHK(result, prev)
      wait_eoc();
      `CHK(result, lvl(1))
      prev = lvl(1);
   endtask : t_abort
   task automatic t_cont;
      host_u.xfer(4'hd, 10, 1'b1, 0, rx);
      `CHK(rx, expv(prev, 10))
      wait_eoc();
      `CHK(data_out, 1'b1)
      host_u.xfer(4'hc, 10, 1'b1, 0, rx);
      `CHK(rx, expv(10'h3ff, 10))
      wait_eoc();
      host_u.xfer(4'h2, 16, 1'b1, 0, rx);
      `CHK(rx, expv(10'h000, 16))
      wait_eoc();
      host_u.xfer(4'h7, 16, 1'b1, 16000, rx);
      `CHK(rx, expv(lvl(2), 16))
      host_u.xfer(4'h0, 16, 1'b1, 0, rx);
      `CHK(rx, expv(lvl(7), 16))
      wait_eoc();
      `CHK(result, lvl(0))
   endtask : t_cont
   task automatic print_verdict;
      $display("Checks %0d, mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : print_verdict
   initial begin
      rst = 1'b1;
      cmp_above = 1'b0;
      held = 10'h000;
      prev = adc_seq_pkg::RESULT_RST;
      n_fail = 0;
      n_checks = 0;
      repeat (6) @(negedge clk_sys);
      rst = 1'b0;
      `CHK(eoc, 1'b1)
      `CHK(data_out_oe, 1'b0)
      t_sweep();
      t_abort();
      t_cont();
      print_verdict();
   end
endmodule : serial_adc_interface_sequencer_tb
